//--- include/pia_regs.vh
// Constants of the prioritized interrupt acceptance block
`ifndef PIA_REGS_VH
`define PIA_REGS_VH
`define PIA_NUM_SRC 34
`define PIA_NUM_TRAP 9
`define PIA_MASK_RESET 3'h7
`define PIA_LVL_NMI 3'h7
`define PIA_LVL_DMA 3'h6
`define PIA_LVL_OFF 3'h0
`define PIA_VEC_BASE 24'hFFFF00
`define PIA_VEC_NMI 8'h20
`define PIA_VEC_WD 8'h24
`define PIA_VEC_FIRST_MASK 8'h28
`define PIA_VEC_UNDEF 8'h08
`define PIA_NEST_W 16
`endif

//--- rtl/pia_pick.v
// Highest-level pending source picker with fixed default order
module pia_pick #(
   parameter N = 34
) (
   input wire [N-1:0] pend_i,
   input wire [3*N-1:0] lvl_i,
   output reg hit_o,
   output reg [2:0] lvl_o,
   output reg [5:0] idx_o
);
   integer k;
   reg [2:0] l;
   always @* begin
      hit_o = 1'b0;
      lvl_o = 3'h0;
      idx_o = 6'h00;
      l = 3'h0;
      for (k = N - 1; k >= 0; k = k - 1) begin
         l = lvl_i[3*k +: 3];
         if (pend_i[k] && l != 3'h0 && (!hit_o || l >= lvl_o)) begin
            hit_o = 1'b1;
            lvl_o = l;
            idx_o = k[5:0];
         end
      end
   end
endmodule // pia_pick

//--- rtl/pia_dma_pick.v
// Micro DMA channel picker: lowest channel first
module pia_dma_pick (
   input wire [3:0] req_i,
   output reg hit_o,
   output reg [1:0] ch_o
);
   always @* begin
      hit_o = |req_i;
      casez (req_i)
         4'b???1: ch_o = 2'h0;
         4'b??10: ch_o = 2'h1;
         4'b?100: ch_o = 2'h2;
         default: ch_o = 2'h3;
      endcase
   end
endmodule // pia_dma_pick

//--- rtl/pia_core.v
// Interrupt controller and CPU acceptance sequencer
// How it works
// - 43 sources: 9 traps, 28 internal, 6 pins
// - Six programmable levels; non-maskable fixed 7
// - Forward level of highest pending request
// - Accept maskable when level at least mask
// - Traps ignore the interrupt mask
// - Enable loads mask; zero acts as one
// - Mask-off instruction sets mask to seven
// - New mask takes effect immediately
// - Acceptance clears the accepted pending request
// - Same level: smaller vector goes first
// - Push program counter and status word
// - Mask becomes level plus one, max seven
// - Nesting counter increments on each trap or interrupt acceptance, not on DMA
// - Fetch handler address at base plus vector
// - Traps fetch a vector but skip mask update
// - Return restores state, decrements nesting counter
// - Level 0 or 7 maskable never accepted
// - Higher level preempts; nesting resumes later
// - No sampling until handler first instruction
// - Reset sets mask to binary 111
// - 256-byte vector table, four-byte entries
// - Undefined opcode trap shares trap 2 vector
// - DMA requests at level 6, channel ordered
`include "pia_regs.vh"
module pia_core #(
   parameter NSRC = `PIA_NUM_SRC
) (
   input wire clk_i,
   input wire rst_b_i,
   // Source index 0 is the NMI pin, 1 the watchdog, rest maskable
   input wire [NSRC-1:0] src_event_i,
   input wire [3*NSRC-1:0] src_level_i,
   // Four bits per source, one per DMA channel it is routed to
   input wire [4*NSRC-1:0] src_dma_ch_i,
   input wire instr_boundary_i,
   input wire enable_interrupts_instr_i,
   input wire [2:0] enable_operand_i,
   input wire mask_off_instr_i,
   input wire software_trap_instr_i,
   input wire [2:0] trap_num_i,
   input wire undefined_opcode_trap_i,
   input wire return_from_handler_instr_i,
   input wire [23:0] extended_stack_pointer_i,
   input wire [15:0] status_word_i,
   input wire [23:0] pc_i,
   input wire [23:0] restored_pc_i,
   input wire [15:0] restored_status_i,
   input wire [23:0] fetched_addr_i,
   input wire mem_done_i,
   output reg [2:0] req_level_o,
   output reg req_valid_o,
   output reg [2:0] interrupt_mask_level_o,
   output reg [`PIA_NEST_W-1:0] nesting_counter_o,
   output reg push_o,
   output reg [23:0] push_addr_o,
   output reg [23:0] push_pc_o,
   output reg [15:0] push_sr_o,
   output reg vec_fetch_o,
   output reg [23:0] vec_addr_o,
   output reg branch_o,
   output reg [23:0] branch_addr_o,
   output reg dma_start_o,
   output reg [1:0] dma_ch_o,
   output reg [2:0] restore_level_o,
   output reg pop_o
);
   // ---------------------------------------------------------------
   // Sequencer states
   // ---------------------------------------------------------------
   localparam ST_IDLE = 3'h0;
   localparam ST_PUSH = 3'h1;
   localparam ST_FETCH = 3'h2;
   localparam ST_BRANCH = 3'h3;
   localparam ST_FIRST = 3'h4;

   function [7:0] src_vec;
      input [5:0] idx;
      begin
         src_vec = `PIA_VEC_NMI + {idx, 2'b00};
         // DMA-end group sits after a gap in the table
         if (idx > 6'd29)
            src_vec = src_vec + 8'h0C;
      end
   endfunction

   function [2:0] eff_level;
      input [5:0] idx;
      input [2:0] lvl;
      begin
         if (idx < 6'd2)
            eff_level = `PIA_LVL_NMI;
         else if (lvl == `PIA_LVL_NMI)
            eff_level = `PIA_LVL_OFF;
         else
            eff_level = lvl;
      end
   endfunction

   reg [2:0] st_q, st_d;
   // one flag per source, traps aside
   reg [NSRC-1:0] pend_q;
   reg [2:0] mask_q;
   reg [`PIA_NEST_W-1:0] nest_q;
   reg [7:0] vec_q;
   reg [5:0] idx_q;
   reg trap_q;
   reg [2:0] acc_lvl_q;
   reg [3*NSRC-1:0] eff_lvl;
   reg [3:0] dma_req;
   integer i;
   integer c;
   integer j;

   wire hit;
   wire [2:0] top_lvl;
   wire [5:0] top_idx;
   wire dma_hit;
   wire [1:0] dma_ch;

   always @* begin
      eff_lvl = {3*NSRC{1'b0}};
      dma_req = 4'h0;
      for (i = 0; i < NSRC; i = i + 1) begin
         eff_lvl[3*i +: 3] = eff_level(i[5:0], src_level_i[3*i +: 3]);
         for (c = 0; c < 4; c = c + 1) begin
            if (pend_q[i] && src_dma_ch_i[4*i + c])
               dma_req[c] = 1'b1;
         end
         if (|src_dma_ch_i[4*i +: 4])
            eff_lvl[3*i +: 3] = `PIA_LVL_OFF;
      end
   end

   pia_pick #(.N(NSRC)) u_pick (
      .pend_i(pend_q),
      .lvl_i(eff_lvl),
      .hit_o(hit),
      .lvl_o(top_lvl),
      .idx_o(top_idx)
   );

   pia_dma_pick u_dma (
      .req_i(dma_req),
      .hit_o(dma_hit),
      .ch_o(dma_ch)
   );

   // ---------------------------------------------------------------
   // Acceptance decision
   // ---------------------------------------------------------------
   wire trap_ev = software_trap_instr_i | undefined_opcode_trap_i;
   // enable operand applies in its own cycle
   wire [2:0] ei_val = (enable_operand_i == 3'h0) ? 3'h1 : enable_operand_i;
   wire [2:0] mask_now = mask_off_instr_i ? `PIA_MASK_RESET :
                         enable_interrupts_instr_i ? ei_val : mask_q;
   wire hw_ok = hit && (top_lvl >= mask_now) &&
                (top_lvl == `PIA_LVL_NMI || top_lvl != 3'h0);
   wire dma_ok = dma_hit && (`PIA_LVL_DMA >= mask_now) &&
                 !(hit && top_lvl > `PIA_LVL_DMA);
   // sample only in idle at boundaries
   wire can_take = (st_q == ST_IDLE) && instr_boundary_i;
   wire take_trap = can_take && trap_ev;
   wire take_dma = can_take && !trap_ev && dma_ok;
   wire take_hw = can_take && !trap_ev && !dma_ok && hw_ok;

   reg [NSRC-1:0] clr;
   always @* begin
      clr = {NSRC{1'b0}};
      if (take_hw)
         clr[top_idx] = 1'b1;
      for (j = 0; j < NSRC; j = j + 1) begin
         if (take_dma && src_dma_ch_i[4*j + dma_ch])
            clr[j] = 1'b1;
      end
   end

   always @* begin
      st_d = st_q;
      case (st_q)
         ST_IDLE: if (take_trap || take_hw) st_d = ST_PUSH;
         ST_PUSH: st_d = ST_FETCH;
         ST_FETCH: if (mem_done_i) st_d = ST_BRANCH;
         ST_BRANCH: st_d = ST_FIRST;
         ST_FIRST: if (instr_boundary_i) st_d = ST_IDLE;
         default: st_d = ST_IDLE;
      endcase
   end

   // ---------------------------------------------------------------
   // State registers
   // ---------------------------------------------------------------
   always @(posedge clk_i) begin
      if (!rst_b_i) begin
         st_q <= ST_IDLE;
         pend_q <= {NSRC{1'b0}};
         mask_q <= `PIA_MASK_RESET;
         nest_q <= {`PIA_NEST_W{1'b0}};
         vec_q <= 8'h00;
         idx_q <= 6'h00;
         trap_q <= 1'b0;
         acc_lvl_q <= 3'h0;
      end else begin
         st_q <= st_d;
         pend_q <= (pend_q & ~clr) | src_event_i;
         if (mask_off_instr_i)
            mask_q <= `PIA_MASK_RESET;
         else if (enable_interrupts_instr_i)
            mask_q <= ei_val;
         if (take_trap) begin
            trap_q <= 1'b1;
            // undefined opcode uses trap 2 vector
            vec_q <= undefined_opcode_trap_i ? `PIA_VEC_UNDEF :
                     {3'h0, trap_num_i, 2'b00};
         end else if (take_hw) begin
            trap_q <= 1'b0;
            idx_q <= top_idx;
            acc_lvl_q <= top_lvl;
            vec_q <= src_vec(top_idx);
         end
         if (st_q == ST_PUSH) begin
            nest_q <= nest_q + 1'b1;
            // mask to level plus one, cap seven
            if (!trap_q)
               mask_q <= (acc_lvl_q == 3'h7) ? 3'h7 : acc_lvl_q + 3'h1;
         end else if (return_from_handler_instr_i && st_q == ST_IDLE) begin
            nest_q <= nest_q - 1'b1;
            mask_q <= restored_status_i[14:12];
         end
      end
   end

   // ---------------------------------------------------------------
   // Registered outputs
   // ---------------------------------------------------------------
   always @(posedge clk_i) begin
      if (!rst_b_i) begin
         req_level_o <= 3'h0;
         req_valid_o <= 1'b0;
         interrupt_mask_level_o <= `PIA_MASK_RESET;
         nesting_counter_o <= {`PIA_NEST_W{1'b0}};
         push_o <= 1'b0;
         push_addr_o <= 24'h000000;
         push_pc_o <= 24'h000000;
         push_sr_o <= 16'h0000;
         vec_fetch_o <= 1'b0;
         vec_addr_o <= 24'h000000;
         branch_o <= 1'b0;
         branch_addr_o <= 24'h000000;
         dma_start_o <= 1'b0;
         dma_ch_o <= 2'h0;
         restore_level_o <= 3'h0;
         pop_o <= 1'b0;
      end else begin
         req_level_o <= hit ? top_lvl : 3'h0;
         req_valid_o <= hit;
         interrupt_mask_level_o <= mask_q;
         nesting_counter_o <= nest_q;
         push_o <= (st_q == ST_PUSH);
         push_addr_o <= extended_stack_pointer_i;
         push_pc_o <= pc_i;
         push_sr_o <= status_word_i;
         // address in the top 256 bytes
         vec_fetch_o <= (st_q == ST_FETCH) && !mem_done_i;
         vec_addr_o <= `PIA_VEC_BASE | {16'h0000, vec_q};
         branch_o <= (st_q == ST_BRANCH);
         // Vector data is only valid in its done cycle
         if (st_q == ST_FETCH && mem_done_i)
            branch_addr_o <= fetched_addr_i;
         dma_start_o <= take_dma;
         dma_ch_o <= dma_ch;
         restore_level_o <= restored_status_i[14:12];
         pop_o <= return_from_handler_instr_i && st_q == ST_IDLE;
      end
   end
endmodule // pia_core

//--- dv/pia_core_checker.sv
// Port assertions for the interrupt acceptance core
module pia_core_checker (
   input wire clk_i,
   input wire rst_b_i,
   input wire enable_interrupts_instr_i,
   input wire [2:0] enable_operand_i,
   input wire mask_off_instr_i,
   input wire mem_done_i,
   input wire [23:0] fetched_addr_i,
   input wire [2:0] interrupt_mask_level_o,
   input wire [15:0] nesting_counter_o,
   input wire push_o,
   input wire vec_fetch_o,
   input wire [23:0] vec_addr_o,
   input wire branch_o,
   input wire [23:0] branch_addr_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   chk_reset_mask: assert property (
      $rose(rst_b_i) |-> interrupt_mask_level_o == 3'h7)
      else $error("mask after reset");
   // Zero operand is folded onto one by the OR
   // Mask output trails the internal mask by one more flop
   chk_enable_load: assert property (
      enable_interrupts_instr_i |-> ##2 interrupt_mask_level_o ==
      ($past(enable_operand_i, 2) |
      {2'h0, $past(enable_operand_i, 2) == 3'h0}))
      else $error("enable mask load");
   chk_mask_off: assert property (
      mask_off_instr_i |-> ##2 interrupt_mask_level_o == 3'h7)
      else $error("mask off");
   chk_nest_step: assert property (
      push_o |=> nesting_counter_o == $past(nesting_counter_o) + 16'h1)
      else $error("nesting step");
   chk_push_pulse: assert property (
      push_o |=> !push_o)
      else $error("push pulse");
   chk_vector_area: assert property (
      vec_fetch_o |-> vec_addr_o[23:8] == 16'hFFFF && vec_addr_o[1:0] == 2'h0)
      else $error("vector area");
   chk_branch_time: assert property (
      vec_fetch_o && mem_done_i |-> ##2 branch_o)
      else $error("branch timing");
   chk_branch_addr: assert property (
      branch_o |-> branch_addr_o == $past(fetched_addr_i, 2))
      else $error("branch target");
endmodule // pia_core_checker
bind pia_core pia_core_checker u_chk (.clk_i, .rst_b_i,
   .enable_interrupts_instr_i, .enable_operand_i, .mask_off_instr_i,
   .mem_done_i, .fetched_addr_i, .interrupt_mask_level_o,
   .nesting_counter_o, .push_o, .vec_fetch_o, .vec_addr_o, .branch_o,
   .branch_addr_o);

//--- dv/pia_mem_model.sv
// Memory side of the vector fetch, answering fast then slow
module pia_mem_model (
   input wire clk_i,
   input wire rst_b_i,
   input wire vec_fetch_o,
   input wire [23:0] vec_addr_o,
   output logic mem_done_i,
   output logic [23:0] fetched_addr_i,
   output logic instr_boundary_i
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] wait_q;
   logic slow_q;
   always @(posedge clk_i) begin
      mem_done_i <= 1'b0;
      instr_boundary_i <= rst_b_i;
      // Data moves every cycle so a stale capture is caught
      fetched_addr_i <= fetched_addr_i + 24'h3;
      if (!rst_b_i) begin
         wait_q <= 2'h0;
         slow_q <= 1'b0;
         fetched_addr_i <= 24'h0;
      end else if (vec_fetch_o && !mem_done_i) begin
         wait_q <= wait_q + 2'h1;
         if (wait_q == {slow_q, 1'b1}) begin
            mem_done_i <= 1'b1;
            fetched_addr_i <= ~vec_addr_o;
            wait_q <= 2'h0;
            slow_q <= !slow_q;
         end
      end
   end
endmodule // pia_mem_model

//--- dv/prioritized_interrupt_acceptance_bench.sv
// Directed bench for the interrupt acceptance core
module prioritized_interrupt_acceptance_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int N = 34;
   logic clk_i = 0, rst_b_i = 0, mem_done_i, instr_boundary_i;
   logic [N-1:0] src_event_i = '0;
   logic [3*N-1:0] src_level_i = '0;
   logic [4*N-1:0] src_dma_ch_i = '0;
   logic enable_interrupts_instr_i = 0, mask_off_instr_i = 0;
   logic software_trap_instr_i = 0, undefined_opcode_trap_i = 0;
   logic return_from_handler_instr_i = 0;
   logic [2:0] enable_operand_i = 0, trap_num_i = 0;
   logic [23:0] extended_stack_pointer_i = 24'h00F000;
   logic [23:0] pc_i = 24'h001234, restored_pc_i = 24'h001234;
   logic [15:0] status_word_i = 16'h7000, restored_status_i = 16'h7000;
   logic [2:0] req_level_o, interrupt_mask_level_o, restore_level_o;
   logic [15:0] nesting_counter_o, push_sr_o;
   logic [23:0] push_addr_o, push_pc_o, vec_addr_o, branch_addr_o;
   logic [23:0] fetched_addr_i, vseen;
   logic [1:0] dma_ch_o;
   logic req_valid_o, push_o, vec_fetch_o, branch_o, dma_start_o, pop_o;
   int err_total = 0, num_checks = 0;
   pia_core #(.NSRC(N)) dut (.clk_i, .rst_b_i, .src_event_i, .src_level_i,
      .src_dma_ch_i, .instr_boundary_i, .enable_interrupts_instr_i,
      .enable_operand_i, .mask_off_instr_i, .software_trap_instr_i,
      .trap_num_i, .undefined_opcode_trap_i, .return_from_handler_instr_i,
      .extended_stack_pointer_i, .status_word_i, .pc_i, .restored_pc_i,
      .restored_status_i, .fetched_addr_i, .mem_done_i, .req_level_o,
      .req_valid_o, .interrupt_mask_level_o, .nesting_counter_o, .push_o,
      .push_addr_o, .push_pc_o, .push_sr_o, .vec_fetch_o, .vec_addr_o,
      .branch_o, .branch_addr_o, .dma_start_o, .dma_ch_o, .restore_level_o,
      .pop_o);
   pia_mem_model u_mem (.clk_i, .rst_b_i, .vec_fetch_o, .vec_addr_o,
      .mem_done_i, .fetched_addr_i, .instr_boundary_i);
   always #2 clk_i = ~clk_i;
   task automatic chk(string nm, logic [23:0] got, logic [23:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s exp %h got %h", nm, exp, got);
      end
   endtask
   task automatic test_done;
      if (err_total == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Sample just after the edge so registered outputs have landed
   task automatic step(int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic ei(logic [2:0] op);
      @(posedge clk_i);
      enable_interrupts_instr_i <= 1;
      enable_operand_i <= op;
      @(posedge clk_i);
      enable_interrupts_instr_i <= 0;
      #1;
   endtask
   task automatic raise(int i, int j, logic [2:0] li, logic [2:0] lj);
      @(posedge clk_i);
      src_level_i[3*i+:3] <= li;
      src_level_i[3*j+:3] <= lj;
      src_event_i[i] <= 1;
      src_event_i[j] <= 1;
      @(posedge clk_i);
      src_event_i <= '0;
   endtask
   task automatic take(logic [23:0] va, logic [2:0] mk, logic [15:0] nst);
      int k;
      int p;
      k = 0;
      p = 0;
      do begin
         step(1);
         if (vec_fetch_o === 1'b1) vseen = vec_addr_o;
         if (push_o === 1'b1) begin
            p++;
            chk("push sp", push_addr_o, 24'h00F000);
            chk("push pc", push_pc_o, 24'h001234);
            chk("push sr", push_sr_o, 24'h007000);
         end
         k++;
      end while (branch_o !== 1'b1 && k < 80);
      if (branch_o !== 1'b1) begin
         err_total++;
         test_done;
      end
      chk("push count", 24'(p), 24'h1);
      chk("vector", vseen, va);
      chk("branch", branch_addr_o, ~va);
      chk("mask", interrupt_mask_level_o, mk);
      chk("nest", nesting_counter_o, nst);
   endtask
   task automatic none(int n);
      int c;
      c = 0;
      repeat (n) begin
         step(1);
         if (push_o === 1'b1 || dma_start_o === 1'b1) c++;
      end
      chk("pushes", 24'(c), 24'h0);
   endtask
   task automatic ret(logic [2:0] lv);
      @(posedge clk_i);
      restored_status_i <= {1'b0, lv, 12'h000};
      return_from_handler_instr_i <= 1;
      @(posedge clk_i);
      return_from_handler_instr_i <= 0;
      #1;
      chk("pop", pop_o, 24'h1);
      chk("restore", restore_level_o, lv);
   endtask
   task automatic s_mask;
      ei(3'h0);
      step(1);
      chk("ei0", interrupt_mask_level_o, 3'h1);
      raise(5, 6, 3'h0, 3'h7);
      none(12);
      ei(3'h5);
      step(1);
      chk("ei5", interrupt_mask_level_o, 3'h5);
      @(posedge clk_i);
      mask_off_instr_i <= 1;
      @(posedge clk_i);
      mask_off_instr_i <= 0;
      step(1);
      chk("off", interrupt_mask_level_o, 3'h7);
   endtask
   task automatic s_hw;
      raise(2, 2, 3'h3, 3'h3);
      none(10);
      chk("req level", req_level_o, 3'h3);
      chk("req valid", req_valid_o, 24'h1);
      ei(3'h4);
      none(10);
      ei(3'h3);
      take(24'hFFFF28, 3'h4, 16'h1);
   endtask
   task automatic s_nest;
      raise(4, 3, 3'h5, 3'h5);
      take(24'hFFFF2C, 3'h6, 16'h2);
      none(8);
      chk("req level", req_level_o, 3'h5);
      ret(3'h4);
      take(24'hFFFF30, 3'h6, 16'h2);
      ret(3'h7);
      step(10);
      chk("nest", nesting_counter_o, 16'h1);
      chk("mask", interrupt_mask_level_o, 3'h7);
   endtask
   task automatic s_trap;
      for (int n = 0; n < 9; n++) begin
         @(posedge clk_i);
         software_trap_instr_i <= (n < 8);
         undefined_opcode_trap_i <= (n == 8);
         trap_num_i <= n[2:0];
         @(posedge clk_i);
         software_trap_instr_i <= 0;
         undefined_opcode_trap_i <= 0;
         // The undefined opcode lands on the third trap entry
         take(n < 8 ? 24'hFFFF00 + 24'(4 * n) : 24'hFFFF08, 3'h7,
            16'(2 + n));
      end
      raise(0, 0, 3'h0, 3'h0);
      take(24'hFFFF20, 3'h7, 16'hB);
   endtask
   // Two routed sources: refused under mask 7, then channel order
   task automatic s_dma;
      @(posedge clk_i);
      src_dma_ch_i[4*10+:4] <= 4'h4;
      src_dma_ch_i[4*12+:4] <= 4'h2;
      raise(10, 12, 3'h1, 3'h1);
      none(6);
      ei(3'h6);
      chk("dma first", dma_start_o, 24'h1);
      chk("dma ch first", dma_ch_o, 24'h1);
      step(1);
      chk("dma second", dma_start_o, 24'h1);
      chk("dma ch second", dma_ch_o, 24'h2);
      step(1);
      chk("dma done", dma_start_o, 24'h0);
   endtask
   initial begin
      repeat (20) @(posedge clk_i);
      rst_b_i <= 1;
      step(1);
      chk("reset mask", interrupt_mask_level_o, 3'h7);
      chk("reset nest", nesting_counter_o, 16'h0);
      s_mask();
      s_hw();
      s_nest();
      s_trap();
      s_dma();
      test_done();
   end
endmodule // prioritized_interrupt_acceptance_bench
